// File: pkg/diag_monitor_pkg.sv
// Contract
// - low registers: result nibble high, tag low
// - high registers read-only, result bits 11:4, reset zero
// - offset 0x64 returns input2 negative high byte
// - offset 0x65 returns negative nibble, tag 0101b
// - offset 0x76 returns temperature high byte
// - offset 0x77 returns temperature nibble, tag 1110b
// - offset 0x78 returns bias current high byte
// - offset 0x79 returns bias nibble, tag 1111b
// - offset 0x7E bits 7-4 give silicon revision
package diag_monitor_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RESULT_W = 12;
   localparam int NIBBLE_W = 4;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] POS2_LOW_OFFSET = 8'h63;
   localparam logic [7:0] NEG2_HIGH_OFFSET = 8'h64;
   localparam logic [7:0] NEG2_LOW_OFFSET = 8'h65;
   localparam logic [7:0] TEMP_HIGH_OFFSET = 8'h76;
   localparam logic [7:0] TEMP_LOW_OFFSET = 8'h77;
   localparam logic [7:0] BIAS_HIGH_OFFSET = 8'h78;
   localparam logic [7:0] BIAS_LOW_OFFSET = 8'h79;
   localparam logic [7:0] REVISION_OFFSET = 8'h7E;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int HIGH_BYTE_MSB = 11;
   localparam int HIGH_BYTE_LSB = 4;
   localparam int LOW_NIBBLE_MSB = 3;

   // ***************************************************************
   // source tags and reset values
   // ***************************************************************
   localparam logic [3:0] POS2_SOURCE_TAG = 4'h4;
   localparam logic [3:0] NEG2_SOURCE_TAG = 4'h5;
   localparam logic [3:0] TEMP_SOURCE_TAG = 4'hE;
   localparam logic [3:0] BIAS_SOURCE_TAG = 4'hF;
   localparam logic [3:0] REVISION_RESERVED = 4'h0;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   localparam logic [7:0] READ_DATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // arbitrary value, not tied to any real silicon
   localparam logic [3:0] REVISION_CODE_DEFAULT = 4'h1;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic load;
      logic [11:0] value;
   } mon_sample_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] addr;
      logic [7:0] wrData;
   } reg_request_t;

endpackage

// File: rtl/diag_monitor_readback_regs.sv
module diag_monitor_readback_regs
#(
   parameter logic [3:0] REVISION_CODE = diag_monitor_pkg::REVISION_CODE_DEFAULT
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire diag_monitor_pkg::reg_request_t regReq,
   input wire diag_monitor_pkg::mon_sample_t pos2Sample,
   input wire diag_monitor_pkg::mon_sample_t neg2Sample,
   input wire diag_monitor_pkg::mon_sample_t tempSample,
   input wire diag_monitor_pkg::mon_sample_t biasSample,
   output logic [7:0] rdData_q,
   output logic rdValid_q
);

   // ***************************************************************
   // stored monitor results
   // ***************************************************************
   logic [3:0] pos2Nibble_q;
   logic [11:0] neg2Result_q;
   logic [11:0] tempResult_q;
   logic [11:0] biasResult_q;
   logic [7:0] rdData_d;

   // ***************************************************************
   // read decode
   // ***************************************************************
   function automatic logic [7:0] high_byte(input logic [11:0] res);
      high_byte = res[diag_monitor_pkg::HIGH_BYTE_MSB:diag_monitor_pkg::HIGH_BYTE_LSB];
   endfunction

   function automatic logic [7:0] low_reg(input logic [11:0] res, input logic [3:0] tag);
      low_reg = {res[diag_monitor_pkg::LOW_NIBBLE_MSB:0], tag};
   endfunction

   function automatic logic [7:0] read_mux
   (
      input logic [7:0] addr,
      input logic [3:0] p2,
      input logic [11:0] n2,
      input logic [11:0] tp,
      input logic [11:0] bi,
      input logic [3:0] rev
   );
      case (addr)
         diag_monitor_pkg::POS2_LOW_OFFSET:
            read_mux = {p2, diag_monitor_pkg::POS2_SOURCE_TAG};
         diag_monitor_pkg::NEG2_HIGH_OFFSET:
            read_mux = high_byte(n2);
         diag_monitor_pkg::NEG2_LOW_OFFSET:
            read_mux = low_reg(n2, diag_monitor_pkg::NEG2_SOURCE_TAG);
         diag_monitor_pkg::TEMP_HIGH_OFFSET:
            read_mux = high_byte(tp);
         diag_monitor_pkg::TEMP_LOW_OFFSET:
            read_mux = low_reg(tp, diag_monitor_pkg::TEMP_SOURCE_TAG);
         diag_monitor_pkg::BIAS_HIGH_OFFSET:
            read_mux = high_byte(bi);
         diag_monitor_pkg::BIAS_LOW_OFFSET:
            read_mux = low_reg(bi, diag_monitor_pkg::BIAS_SOURCE_TAG);
         diag_monitor_pkg::REVISION_OFFSET:
            read_mux = {rev, diag_monitor_pkg::REVISION_RESERVED};
         default:
            read_mux = diag_monitor_pkg::UNMAPPED_DATA;
      endcase
   endfunction

   always_comb
   begin
      rdData_d = read_mux(regReq.addr, pos2Nibble_q, neg2Result_q, tempResult_q,
         biasResult_q, REVISION_CODE);
   end

   // ***************************************************************
   // result capture, only the monitor can load
   // ***************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pos2Nibble_q <= diag_monitor_pkg::NIBBLE_RESET;
      end
      else if (pos2Sample.load)
      begin
         pos2Nibble_q <= pos2Sample.value[diag_monitor_pkg::LOW_NIBBLE_MSB:0];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         neg2Result_q <= diag_monitor_pkg::RESULT_RESET;
      end
      else if (neg2Sample.load)
      begin
         neg2Result_q <= neg2Sample.value;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tempResult_q <= diag_monitor_pkg::RESULT_RESET;
      end
      else if (tempSample.load)
      begin
         tempResult_q <= tempSample.value;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         biasResult_q <= diag_monitor_pkg::RESULT_RESET;
      end
      else if (biasSample.load)
      begin
         biasResult_q <= biasSample.value;
      end
   end

   // ***************************************************************
   // read port, one cycle latency, writes ignored
   // ***************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdData_q <= diag_monitor_pkg::READ_DATA_RESET;
         rdValid_q <= 1'b0;
      end
      else
      begin
         rdValid_q <= regReq.read;
         if (regReq.read)
         begin
            rdData_q <= rdData_d;
         end
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_pos2_low_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::POS2_LOW_OFFSET
      |=> rdValid_q && rdData_q == {$past(pos2Nibble_q), diag_monitor_pkg::POS2_SOURCE_TAG})
      else $error("input2 positive low register read wrong");

   a_high_reset_zero: assert property (
      $past(reset) |-> neg2Result_q == 12'h000 && tempResult_q == 12'h000
      && biasResult_q == 12'h000)
      else $error("high byte results not zero after reset");

   a_neg2_high_read: assert property (
      neg2Sample.load ##1 (regReq.read && regReq.addr == diag_monitor_pkg::NEG2_HIGH_OFFSET
      && !neg2Sample.load) |=> rdData_q == $past(neg2Sample.value[11:4], 2))
      else $error("input2 negative high byte wrong");

   a_neg2_low_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::NEG2_LOW_OFFSET
      |=> rdValid_q && rdData_q[3:0] == 4'h5 && rdData_q[7:4] == $past(neg2Result_q[3:0]))
      else $error("input2 negative low register wrong");

   a_temp_high_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::TEMP_HIGH_OFFSET
      |=> rdData_q == $past(tempResult_q[11:4]))
      else $error("temperature high byte wrong");

   a_temp_low_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::TEMP_LOW_OFFSET
      |=> rdData_q == {$past(tempResult_q[3:0]), 4'hE})
      else $error("temperature low register wrong");

   a_bias_high_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::BIAS_HIGH_OFFSET
      |=> rdData_q == $past(biasResult_q[11:4]))
      else $error("bias current high byte wrong");

   a_bias_low_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::BIAS_LOW_OFFSET
      |=> rdData_q == {$past(biasResult_q[3:0]), 4'hF})
      else $error("bias current low register wrong");

   a_revision_read: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::REVISION_OFFSET
      |=> rdData_q[7:4] == REVISION_CODE)
      else $error("revision code wrong");

   a_reserved_zero: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::REVISION_OFFSET
      |=> rdData_q[3:0] == diag_monitor_pkg::REVISION_RESERVED)
      else $error("reserved revision bits not zero");

   a_write_ignored: assert property (
      regReq.write && !neg2Sample.load && !tempSample.load && !biasSample.load
      && !pos2Sample.load
      |=> $stable(neg2Result_q) && $stable(tempResult_q) && $stable(biasResult_q)
      && $stable(pos2Nibble_q))
      else $error("write changed a stored result");

   a_unmapped_zero: assert property (
      regReq.read && regReq.addr == 8'h62 |=> rdValid_q && rdData_q == 8'h00)
      else $error("unmapped read below the map not zero");

   a_above_map_zero: assert property (
      regReq.read && regReq.addr == 8'h7F |=> rdValid_q && rdData_q == 8'h00)
      else $error("unmapped read above the map not zero");

   // ***************************************************************
   // read port handshake
   // ***************************************************************
   a_valid_after_read: assert property (
      regReq.read |=> rdValid_q)
      else $error("read not answered one cycle later");

   a_valid_only_read: assert property (
      !regReq.read |=> !rdValid_q)
      else $error("read valid without a read request");

   a_data_held: assert property (
      !regReq.read |=> $stable(rdData_q))
      else $error("read data changed without a read");

   a_write_no_answer: assert property (
      regReq.write && !regReq.read |=> !rdValid_q && $stable(rdData_q))
      else $error("write produced read data");

   a_read_beats_write: assert property (
      regReq.read && regReq.write && regReq.addr == diag_monitor_pkg::NEG2_LOW_OFFSET
      |=> rdValid_q
      && rdData_q == {$past(neg2Result_q[3:0]), diag_monitor_pkg::NEG2_SOURCE_TAG})
      else $error("read in a write cycle not served");

   // ***************************************************************
   // result storage
   // ***************************************************************
   a_pos2_load_store: assert property (
      pos2Sample.load |=> pos2Nibble_q == $past(pos2Sample.value[3:0]))
      else $error("input2 positive nibble not stored");

   a_neg2_load_store: assert property (
      neg2Sample.load |=> neg2Result_q == $past(neg2Sample.value))
      else $error("input2 negative result not stored");

   a_temp_load_store: assert property (
      tempSample.load |=> tempResult_q == $past(tempSample.value))
      else $error("temperature result not stored");

   a_bias_load_store: assert property (
      biasSample.load |=> biasResult_q == $past(biasSample.value))
      else $error("bias current result not stored");

   a_pos2_held: assert property (
      !pos2Sample.load |=> $stable(pos2Nibble_q))
      else $error("input2 positive nibble changed without a load");

   a_neg2_held: assert property (
      !neg2Sample.load |=> $stable(neg2Result_q))
      else $error("input2 negative result changed without a load");

   a_temp_held: assert property (
      !tempSample.load |=> $stable(tempResult_q))
      else $error("temperature result changed without a load");

   a_bias_held: assert property (
      !biasSample.load |=> $stable(biasResult_q))
      else $error("bias current result changed without a load");

   // ***************************************************************
   // reset and revision
   // ***************************************************************
   a_port_reset_idle: assert property (
      $past(reset) |-> !rdValid_q && rdData_q == diag_monitor_pkg::READ_DATA_RESET)
      else $error("read port not idle after reset");

   a_pos2_reset_zero: assert property (
      $past(reset) |-> pos2Nibble_q == diag_monitor_pkg::NIBBLE_RESET)
      else $error("input2 positive nibble not zero after reset");

   a_revision_full: assert property (
      regReq.read && regReq.addr == diag_monitor_pkg::REVISION_OFFSET
      |=> rdData_q == {REVISION_CODE, diag_monitor_pkg::REVISION_RESERVED})
      else $error("revision register wrong");

   // ***************************************************************
   // coverage
   // ***************************************************************
   c_temp_load_read: cover property (
      tempSample.load ##1 regReq.read && regReq.addr == diag_monitor_pkg::TEMP_HIGH_OFFSET);
   c_bias_back_to_back: cover property (
      regReq.read ##1 regReq.read && regReq.addr == diag_monitor_pkg::BIAS_LOW_OFFSET);
   c_write_revision: cover property (
      regReq.write && regReq.addr == diag_monitor_pkg::REVISION_OFFSET);
   c_load_during_read: cover property (
      neg2Sample.load && regReq.read && regReq.addr == diag_monitor_pkg::NEG2_HIGH_OFFSET);
   c_read_write_same: cover property (
      regReq.read && regReq.write);

endmodule // diag_monitor_readback_regs

// File: verif/tb_diag_monitor_readback_regs.sv
`define CHK(got, exp) \
   begin \
      nCompared++; \
      if ((got) !== (exp)) \
      begin \
         errTotal++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_diag_monitor_readback_regs;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   diag_monitor_pkg::reg_request_t regReq = '0;
   diag_monitor_pkg::mon_sample_t pos2Sample = '0;
   diag_monitor_pkg::mon_sample_t neg2Sample = '0;
   diag_monitor_pkg::mon_sample_t tempSample = '0;
   diag_monitor_pkg::mon_sample_t biasSample = '0;
   logic [7:0] rdData_q;
   logic rdValid_q;
   int errTotal = 0;
   int nCompared = 0;
   // revision code is an arbitrary value
   localparam logic [3:0] REV = 4'h3;
   localparam logic [7:0] ADDRS [10] = '{8'h63, 8'h64, 8'h65, 8'h76, 8'h77, 8'h78, 8'h79,
      8'h7E, 8'h62, 8'h7F};
   localparam logic [7:0] RESET_MAP [10] = '{8'h04, 8'h00, 8'h05, 8'h00, 8'h0E, 8'h00, 8'h0F,
      {REV, 4'h0}, 8'h00, 8'h00};
   localparam logic [7:0] LOADED_MAP [10] = '{8'hC4, 8'h3B, 8'h75, 8'hF0, 8'hEE, 8'h81, 8'h2F,
      {REV, 4'h0}, 8'h00, 8'h00};
   diag_monitor_readback_regs #(.REVISION_CODE(REV)) diag_monitor_readback_regs_i (
      .sys_clk(sys_clk),
      .reset(reset),
      .regReq(regReq),
      .pos2Sample(pos2Sample),
      .neg2Sample(neg2Sample),
      .tempSample(tempSample),
      .biasSample(biasSample),
      .rdData_q(rdData_q),
      .rdValid_q(rdValid_q)
   );
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic do_reset();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
      `CHK(rdValid_q, 1'b0)
      @(posedge sys_clk);
      reset <= 1'b0;
   endtask
   // back-to-back reads of every offset, one per cycle
   task automatic check_map(input logic [7:0] exp [10]);
      for (int i = 0; i <= 10; i++)
      begin
         @(posedge sys_clk);
         if (i < 10)
            regReq <= '{1'b1, 1'b0, ADDRS[i], 8'h00};
         else
            regReq <= '0;
         if (i > 0)
         begin
            #1;
            `CHK({rdValid_q, rdData_q}, {1'b1, exp[i - 1]})
         end
      end
      @(posedge sys_clk);
      #1;
      `CHK(rdValid_q, 1'b0)
   endtask
   task automatic test_reset_values();
      do_reset();
      check_map(RESET_MAP);
      $display("test reset values done");
   endtask
   task automatic test_loaded_values();
      @(posedge sys_clk);
      pos2Sample <= '{1'b1, 12'hA5C};
      neg2Sample <= '{1'b1, 12'h3B7};
      tempSample <= '{1'b1, 12'hF0E};
      biasSample <= '{1'b1, 12'h812};
      @(posedge sys_clk);
      pos2Sample <= '0;
      neg2Sample <= '0;
      tempSample <= '0;
      biasSample <= '0;
      check_map(LOADED_MAP);
      $display("test loaded values done");
   endtask
   // writes of ones everywhere, zeros to the revision register
   task automatic test_writes_ignored();
      for (int i = 0; i < 10; i++)
      begin
         @(posedge sys_clk);
         regReq <= '{1'b0, 1'b1, ADDRS[i], (i == 7) ? 8'h00 : 8'hFF};
      end
      @(posedge sys_clk);
      regReq <= '0;
      #1;
      `CHK(rdValid_q, 1'b0)
      check_map(LOADED_MAP);
      $display("test writes ignored done");
   endtask
   // a read in the load cycle still sees the old result
   task automatic test_load_during_read();
      @(posedge sys_clk);
      neg2Sample <= '{1'b1, 12'h6D9};
      regReq <= '{1'b1, 1'b0, 8'h64, 8'h00};
      @(posedge sys_clk);
      neg2Sample <= '0;
      tempSample <= '{1'b1, 12'h5A3};
      #1;
      `CHK(rdData_q, 8'h3B)
      @(posedge sys_clk);
      tempSample <= '0;
      regReq <= '{1'b1, 1'b0, 8'h76, 8'h00};
      #1;
      `CHK(rdData_q, 8'h6D)
      @(posedge sys_clk);
      regReq <= '{1'b1, 1'b1, 8'h65, 8'hFF};
      #1;
      `CHK(rdData_q, 8'h5A)
      @(posedge sys_clk);
      regReq <= '0;
      #1;
      `CHK({rdValid_q, rdData_q}, 9'h195)
      $display("test load during read done");
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      test_reset_values();
      test_loaded_values();
      test_writes_ignored();
      test_load_during_read();
      test_reset_values();
      complete_run();
   end
   initial
   begin
      #(25 * 5000);
      errTotal++;
      complete_run();
   end
endmodule // tb_diag_monitor_readback_regs
